// ===== hw/gt_params.svh
// offsets, field positions, reset values and counts of the general timer unit
`ifndef GT_PARAMS_SVH
`define GT_PARAMS_SVH
// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define GT_OFF_CFG      8'h00
`define GT_OFF_MODE_A   8'h04
`define GT_OFF_MODE_B   8'h08
`define GT_OFF_CTL      8'h0C
`define GT_OFF_IMR      8'h18
`define GT_OFF_RIS      8'h1C
`define GT_OFF_MIS      8'h20
`define GT_OFF_ICR      8'h24
`define GT_OFF_LOAD_A   8'h28
`define GT_OFF_LOAD_B   8'h2C
`define GT_OFF_MATCH_A  8'h30
`define GT_OFF_MATCH_B  8'h34
`define GT_OFF_PRE_A    8'h38
`define GT_OFF_PRE_B    8'h3C
`define GT_OFF_COUNT_A  8'h48
`define GT_OFF_COUNT_B  8'h4C
// ----------------------------------------------------------------------------
// field encodings and positions
// ----------------------------------------------------------------------------
`define GT_CFG_32BIT    3'h0
`define GT_CFG_RTC      3'h1
`define GT_CFG_HALF_BIT 2
`define GT_MR_ONESHOT   2'h1
`define GT_MR_PERIODIC  2'h2
`define GT_MR_CAPTURE   2'h3
`define GT_MR_AMS       3
`define GT_MR_CMR       2
`define GT_CTL_STRIDE   8
`define GT_CTL_EN       0
`define GT_CTL_STALL    1
`define GT_CTL_EVT      2
`define GT_CTL_RTC_DEBUG_STALL_ENABLE    4
`define GT_CTL_INV      6
`define GT_CTL_WMASK    16'h4F5F
`define GT_EVT_RISE     2'h0
`define GT_EVT_FALL     2'h1
`define GT_FLAG_STRIDE  8
`define GT_FLAG_TO      0
`define GT_FLAG_CM      1
`define GT_FLAG_CE      2
`define GT_FLAG_RTC     3
`define GT_FLAG_MASK    32'h0000070F
// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define GT_LOAD_RST     16'hFFFF
`define GT_RTC_PRELOAD  32'h00000001
`define GT_RTC_DIV      32768
`endif

// ===== hw/gt_pkg.sv
// types shared by the general timer unit
package gt_pkg;
  typedef enum logic [2:0] {
    HM_IDLE,
    HM_ONESHOT,
    HM_PERIODIC,
    HM_ECOUNT,
    HM_ETIME,
    HM_PWM
  } half_mode_e;
  typedef logic [15:0] half_word_t;
endpackage

// ===== hw/ccp_edge_sync.sv
// three-stage pin synchroniser with rise and fall pulses
`timescale 1ns/10ps
module ccp_edge_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  // a change counts only once stages two and three agree; stage one feeds stage two alone
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else begin
      s1_q   <= pin_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (s2_q == s3_q && s3_q != level_q) begin
        level_q <= s3_q;
        rise_o  <= s3_q;
        fall_o  <= !s3_q;
      end
    end
  end
endmodule

// ===== hw/general_timer_unit.sv
// general timer unit: two 16-bit halves, 32-bit and rtc modes, capture and pwm, avalon slave
`timescale 1ns/10ps
`include "gt_params.svh"
// What this block does
// - edge time half free-runs down from its load value; load resets to 0xFFFF.
// - event control field picks rising, falling or both edges for capture.
// - edge time capture copies count to readable register, sets edge event flag.
// - after capture keep counting; at 0x0000 reload from load register.
// - captured count holds until next selected edge overwrites it.
// - prescaler bypassed in 16-bit edge time and pwm modes.
// - pwm selected by alternate bit 1, capture kind 0, mode field 2.
// - pwm counts down to 0x0000, reloads next cycle, repeats while enabled.
// - pwm mode never sets any status flag.
// - pwm output active at load value, inactive at match value.
// - invert control bit inverts the pwm output.
// - load write in pwm changes period next cycle without stopping.
// - load write in edge time while running takes effect next cycle.
// - width config 0 is 32-bit timer, 1 rtc counter, 4 split halves.
// - mode field 1 one-shot stops at time-out, 2 periodic keeps counting.
// - capture kind 0 with mode 3 edge count; kind 1 with mode 3 edge time.
// - edge count stops after programmed edges, ignores more until re-enabled.
// - writing 1 to clear register clears raw and masked flag; mask gates.
// - rtc count equal to match sets rtc flag; counts until disabled or reset.
// - rtc debug stall bit set keeps timer running through a debugger halt.
// - edge count decrements per edge; at match flag, reload, clear enable.
module general_timer_unit
  import gt_pkg::*;
#(
  parameter int RTC_DIV = `GT_RTC_DIV
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire logic        debug_halt_i,
  input  wire logic        ccp_a_i,
  input  wire logic        ccp_b_i,
  output logic             ccp_a_o,
  output logic             ccp_a_oe_o,
  output logic             ccp_b_o,
  output logic             ccp_b_oe_o
);
  localparam int DIV_W = $clog2(RTC_DIV);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic half_mode_e decode_mode(input logic [3:0] mr);
    half_mode_e m;
    m = HM_IDLE;
    if (mr[`GT_MR_AMS]) begin
      if (!mr[`GT_MR_CMR] && mr[1:0] == `GT_MR_PERIODIC) m = HM_PWM;
    end else begin
      case (mr[1:0])
        `GT_MR_ONESHOT:  m = HM_ONESHOT;
        `GT_MR_PERIODIC: m = HM_PERIODIC;
        `GT_MR_CAPTURE:  m = mr[`GT_MR_CMR] ? HM_ETIME : HM_ECOUNT;
        default:         m = HM_IDLE;
      endcase
    end
    return m;
  endfunction

  function automatic logic edge_hit(input logic [1:0] evt, input logic rise, input logic fall);
    case (evt)
      `GT_EVT_RISE: return rise;
      `GT_EVT_FALL: return fall;
      default:      return rise | fall;
    endcase
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  // a zero count or a fresh load write both restart from the load value
  function automatic half_word_t down_reload(input half_word_t c, input half_word_t ld, input logic wr);
    return (wr || c == 16'h0000) ? ld : c - 16'h0001;
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [2:0]       cfg_q;
  logic [3:0]       mr_q     [2];
  logic [15:0]      ctl_q;
  logic [31:0]      imr_q;
  logic [31:0]      ris_q;
  half_word_t       ld_q     [2];
  half_word_t       match_q  [2];
  half_word_t       cnt_q    [2];
  half_word_t       cnt_d    [2];
  half_word_t       cap_q    [2];
  half_word_t       cap_d    [2];
  logic [7:0]       pr_q     [2];
  logic [7:0]       psc_q    [2];
  logic [7:0]       psc_d    [2];
  half_mode_e       hmode    [2];
  logic [1:0]       ld_wr_q;
  logic [1:0]       lvl_q;
  logic [1:0]       lvl_d;
  logic [1:0]       en_clr;
  logic [1:0]       run;
  logic [1:0]       rise;
  logic [1:0]       fall;
  logic [1:0]       edge_sel;
  logic [1:0]       pin_q;
  logic [1:0]       oe_q;
  logic [31:0]      set_d;
  logic [31:0]      rd_word;
  logic [31:0]      wdat;
  logic [31:0]      rdata_q;
  logic             wait_q;
  logic             wr_acc;
  logic             rtc_preload;
  logic             cfg16;
  logic [DIV_W-1:0] rtc_div_q;
  logic             rtc_tick_q;

  // --------------------------------------------------------------------------
  // pin synchronisers (capture inputs and rtc source on the even pin)
  // --------------------------------------------------------------------------
  ccp_edge_sync u_sync_a (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (ccp_a_i),
    .rise_o  (rise[0]),
    .fall_o  (fall[0])
  );

  ccp_edge_sync u_sync_b (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (ccp_b_i),
    .rise_o  (rise[1]),
    .fall_o  (fall[1])
  );

  // --------------------------------------------------------------------------
  // per-half decode
  // --------------------------------------------------------------------------
  assign cfg16 = cfg_q[`GT_CFG_HALF_BIT];

  always_comb begin
    for (int h = 0; h < 2; h++) begin
      hmode[h]    = decode_mode(mr_q[h]);
      // rtc stall bit overrides both per-half freeze bits
      run[h]      = ctl_q[h*`GT_CTL_STRIDE + `GT_CTL_EN] &&
                    !(debug_halt_i && ctl_q[h*`GT_CTL_STRIDE + `GT_CTL_STALL] && !ctl_q[`GT_CTL_RTC_DEBUG_STALL_ENABLE]);
      edge_sel[h] = edge_hit(ctl_q[h*`GT_CTL_STRIDE + `GT_CTL_EVT +: 2], rise[h], fall[h]);
    end
  end

  // --------------------------------------------------------------------------
  // avalon slave: one wait cycle, read data registered
  // --------------------------------------------------------------------------
  function automatic logic wr_to(input logic [7:0] off);
    return wr_acc && (address_i == off);
  endfunction

  always_comb begin
    rd_word = 32'h00000000;
    case (address_i)
      `GT_OFF_CFG:     rd_word = {29'h0, cfg_q};
      `GT_OFF_MODE_A:  rd_word = {28'h0, mr_q[0]};
      `GT_OFF_MODE_B:  rd_word = {28'h0, mr_q[1]};
      `GT_OFF_CTL:     rd_word = {16'h0, ctl_q};
      `GT_OFF_IMR:     rd_word = imr_q;
      `GT_OFF_RIS:     rd_word = ris_q;
      `GT_OFF_MIS:     rd_word = ris_q & imr_q;
      `GT_OFF_LOAD_A:  rd_word = cfg16 ? {16'h0, ld_q[0]} : {ld_q[1], ld_q[0]};
      `GT_OFF_LOAD_B:  rd_word = {16'h0, ld_q[1]};
      `GT_OFF_MATCH_A: rd_word = cfg16 ? {16'h0, match_q[0]} : {match_q[1], match_q[0]};
      `GT_OFF_MATCH_B: rd_word = {16'h0, match_q[1]};
      `GT_OFF_PRE_A:   rd_word = {24'h0, pr_q[0]};
      `GT_OFF_PRE_B:   rd_word = {24'h0, pr_q[1]};
      `GT_OFF_COUNT_A: rd_word = !cfg16 ? {cnt_q[1], cnt_q[0]} :
                                 {16'h0, (hmode[0] == HM_ETIME) ? cap_q[0] : cnt_q[0]};
      `GT_OFF_COUNT_B: rd_word = {16'h0, (hmode[1] == HM_ETIME) ? cap_q[1] : cnt_q[1]};
      default:         rd_word = 32'h00000000;
    endcase
  end

  assign wdat        = be_merge(rd_word, writedata_i, byteenable_i);
  assign wr_acc      = write_i && !wait_q;
  assign rtc_preload = wr_to(`GT_OFF_CFG) && wdat[2:0] == `GT_CFG_RTC;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else if ((read_i || write_i) && wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= read_i ? rd_word : 32'h00000000;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  assign readdata_o    = rdata_q;
  assign waitrequest_o = wait_q;

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_q   <= `GT_CFG_32BIT;
      mr_q[0] <= 4'h0;
      mr_q[1] <= 4'h0;
      imr_q   <= 32'h00000000;
      pr_q[0] <= 8'h00;
      pr_q[1] <= 8'h00;
    end else begin
      if (wr_to(`GT_OFF_CFG)) cfg_q <= wdat[2:0];
      if (wr_to(`GT_OFF_MODE_A)) mr_q[0] <= wdat[3:0];
      if (wr_to(`GT_OFF_MODE_B)) mr_q[1] <= wdat[3:0];
      if (wr_to(`GT_OFF_IMR)) imr_q <= wdat & `GT_FLAG_MASK;
      if (wr_to(`GT_OFF_PRE_A)) pr_q[0] <= wdat[7:0];
      if (wr_to(`GT_OFF_PRE_B)) pr_q[1] <= wdat[7:0];
    end
  end

  // load and match; in 32-bit configurations the first half's word spans both halves
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ld_q[0]    <= `GT_LOAD_RST;
      ld_q[1]    <= `GT_LOAD_RST;
      match_q[0] <= `GT_LOAD_RST;
      match_q[1] <= `GT_LOAD_RST;
      ld_wr_q    <= 2'b00;
    end else begin
      ld_wr_q <= 2'b00;
      if (wr_to(`GT_OFF_LOAD_A)) begin
        ld_q[0]    <= wdat[15:0];
        ld_wr_q[0] <= 1'b1;
        if (!cfg16) begin
          ld_q[1]    <= wdat[31:16];
          ld_wr_q[1] <= 1'b1;
        end
      end
      if (wr_to(`GT_OFF_LOAD_B)) begin
        ld_q[1]    <= wdat[15:0];
        ld_wr_q[1] <= 1'b1;
      end
      if (wr_to(`GT_OFF_MATCH_A)) begin
        match_q[0] <= wdat[15:0];
        if (!cfg16) match_q[1] <= wdat[31:16];
      end
      if (wr_to(`GT_OFF_MATCH_B)) match_q[1] <= wdat[15:0];
    end
  end

  // software write to control wins over a hardware enable clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_q <= 16'h0000;
    end else if (wr_to(`GT_OFF_CTL)) begin
      ctl_q <= wdat[15:0] & `GT_CTL_WMASK;
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (en_clr[h]) ctl_q[h*`GT_CTL_STRIDE + `GT_CTL_EN] <= 1'b0;
      end
    end
  end

  // a new event in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ris_q <= 32'h00000000;
    end else begin
      ris_q <= (ris_q & ~(wr_to(`GT_OFF_ICR) ? wdat : 32'h00000000)) | set_d;
    end
  end

  // --------------------------------------------------------------------------
  // rtc divider: rising edges of the even pin down to a one-cycle second tick
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rtc_div_q  <= '0;
      rtc_tick_q <= 1'b0;
    end else begin
      rtc_tick_q <= 1'b0;
      if (cfg_q != `GT_CFG_RTC || !ctl_q[`GT_CTL_EN]) begin
        rtc_div_q <= '0;
      end else if (rise[0]) begin
        if (rtc_div_q == DIV_W'(RTC_DIV - 1)) begin
          rtc_div_q  <= '0;
          rtc_tick_q <= 1'b1;
        end else begin
          rtc_div_q <= rtc_div_q + DIV_W'(1);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // counting
  // --------------------------------------------------------------------------
  always_comb begin
    logic [31:0] c32;
    logic [31:0] l32;
    logic [31:0] m32;
    c32    = {cnt_q[1], cnt_q[0]};
    l32    = {ld_q[1], ld_q[0]};
    m32    = {match_q[1], match_q[0]};
    set_d  = 32'h00000000;
    en_clr = 2'b00;
    for (int h = 0; h < 2; h++) begin
      cnt_d[h] = cnt_q[h];
      cap_d[h] = cap_q[h];
      psc_d[h] = psc_q[h];
      lvl_d[h] = lvl_q[h];
    end
    if (cfg16) begin
      for (int h = 0; h < 2; h++) begin
        if (!ctl_q[h*`GT_CTL_STRIDE + `GT_CTL_EN]) begin
          lvl_d[h] = 1'b0;
          // a load written while stopped is the start value of the next run
          if (ld_wr_q[h]) cnt_d[h] = ld_q[h];
        end else if (run[h]) begin
          case (hmode[h])
            HM_ONESHOT, HM_PERIODIC: begin
              if (ld_wr_q[h]) begin
                cnt_d[h] = ld_q[h];
                psc_d[h] = pr_q[h];
              end else if (psc_q[h] != 8'h00) begin
                psc_d[h] = psc_q[h] - 8'h01;
              end else begin
                psc_d[h] = pr_q[h];
                if (cnt_q[h] == 16'h0000) begin
                  cnt_d[h] = ld_q[h];
                  set_d[h*`GT_FLAG_STRIDE + `GT_FLAG_TO] = 1'b1;
                  if (hmode[h] == HM_ONESHOT) en_clr[h] = 1'b1;
                end else begin
                  cnt_d[h] = cnt_q[h] - 16'h0001;
                end
              end
            end
            HM_ECOUNT: begin
              if (edge_sel[h]) begin
                if (cnt_q[h] - 16'h0001 == match_q[h]) begin
                  cnt_d[h]  = ld_q[h];
                  set_d[h*`GT_FLAG_STRIDE + `GT_FLAG_CM] = 1'b1;
                  en_clr[h] = 1'b1;
                end else begin
                  cnt_d[h] = cnt_q[h] - 16'h0001;
                end
              end
            end
            HM_ETIME: begin
              cnt_d[h] = down_reload(cnt_q[h], ld_q[h], ld_wr_q[h]);
              if (edge_sel[h]) begin
                cap_d[h] = cnt_q[h];
                set_d[h*`GT_FLAG_STRIDE + `GT_FLAG_CE] = 1'b1;
              end
            end
            HM_PWM: begin
              // no flag is ever raised here
              cnt_d[h] = down_reload(cnt_q[h], ld_q[h], ld_wr_q[h]);
              if (cnt_q[h] == ld_q[h]) begin
                lvl_d[h] = 1'b1;
              end else if (cnt_q[h] == match_q[h]) begin
                lvl_d[h] = 1'b0;
              end
            end
            default: begin
              cnt_d[h] = cnt_q[h];
            end
          endcase
        end
      end
    end else if (run[0]) begin
      if (cfg_q == `GT_CFG_32BIT && (hmode[0] == HM_ONESHOT || hmode[0] == HM_PERIODIC)) begin
        if (ld_wr_q[0]) begin
          c32 = l32;
        end else if (c32 == 32'h00000000) begin
          c32 = l32;
          set_d[`GT_FLAG_TO] = 1'b1;
          if (hmode[0] == HM_ONESHOT) en_clr[0] = 1'b1;
        end else begin
          c32 = c32 - 32'h00000001;
        end
      end else if (cfg_q == `GT_CFG_RTC && rtc_tick_q) begin
        if (c32 == m32) begin
          c32 = 32'h00000000;
          set_d[`GT_FLAG_RTC] = 1'b1;
        end else begin
          c32 = c32 + 32'h00000001;
        end
      end
      cnt_d[0] = c32[15:0];
      cnt_d[1] = c32[31:16];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int h = 0; h < 2; h++) begin
        cnt_q[h] <= `GT_LOAD_RST;
        cap_q[h] <= 16'h0000;
        psc_q[h] <= 8'h00;
      end
      lvl_q <= 2'b00;
    end else begin
      for (int h = 0; h < 2; h++) begin
        cap_q[h] <= cap_d[h];
        psc_q[h] <= psc_d[h];
      end
      lvl_q <= lvl_d;
      if (rtc_preload) begin
        cnt_q[0] <= 16'(`GT_RTC_PRELOAD);
        cnt_q[1] <= 16'(`GT_RTC_PRELOAD >> 16);
      end else begin
        cnt_q[0] <= cnt_d[0];
        cnt_q[1] <= cnt_d[1];
      end
    end
  end

  // --------------------------------------------------------------------------
  // pwm pins
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_q <= 2'b00;
      oe_q  <= 2'b00;
    end else begin
      for (int h = 0; h < 2; h++) begin
        pin_q[h] <= cfg16 && hmode[h] == HM_PWM && (lvl_q[h] ^ ctl_q[h*`GT_CTL_STRIDE + `GT_CTL_INV]);
        oe_q[h]  <= cfg16 && hmode[h] == HM_PWM;
      end
    end
  end

  assign ccp_a_o    = pin_q[0];
  assign ccp_a_oe_o = oe_q[0];
  assign ccp_b_o    = pin_q[1];
  assign ccp_b_oe_o = oe_q[1];
endmodule

// ===== test/gt_pins_model.sv
// pin-side model driving the two capture pins of the timer
`timescale 1ns/10ps
module gt_pins_model #(
  parameter int HOLD = 3
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] tog_i,
  output logic            pin_a_o,
  output logic            pin_b_o
);
  logic [1:0] pin_q = 2'b00;
  int         held [2] = '{0, 0};
  assign pin_a_o = pin_q[0];
  assign pin_b_o = pin_q[1];
  // a toggle asked for too soon is dropped, so the sampler never sees a short level
  always @(posedge clk_i)
    for (int k = 0; k < 2; k++)
      if (tog_i[k] && held[k] >= HOLD) begin
        pin_q[k] <= ~pin_q[k];
        held[k] <= 0;
      end else if (held[k] < HOLD) begin
        held[k] <= held[k] + 1;
      end
endmodule

// ===== test/general_timer_unit_asserts.sv
// port-level assertions of the general timer unit
`timescale 1ns/10ps
module general_timer_unit_asserts (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        ccp_a_o,
  input wire logic        ccp_a_oe_o,
  input wire logic        ccp_b_o,
  input wire logic        ccp_b_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // bus handshake
  // ----
  sequence s_req;
    (read_i || write_i) && waitrequest_o;
  endsequence
  sequence s_idle;
    !(read_i || write_i);
  endsequence
  a_wait_answer: assert property (s_req |=> !waitrequest_o)
    else $error("no answer one cycle after a request");
  a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("wait low for more than one cycle");
  a_idle_wait: assert property (s_idle |-> waitrequest_o)
    else $error("wait low without a request");
  a_write_zero: assert property (!waitrequest_o && write_i |-> readdata_o == 32'h0)
    else $error("read data not zero on a write");
  a_rdata_hold: assert property (s_idle ##1 s_idle |-> $stable(readdata_o))
    else $error("read data moved with no request");
  // ----
  // pwm pins
  // ----
  // pin and enable registers load on the same edge from the same pwm condition; the check still waits three low cycles
  a_pin_a_off: assert property (!ccp_a_oe_o [*3] |-> !ccp_a_o)
    else $error("pin a driven outside pwm");
  a_pin_b_off: assert property (!ccp_b_oe_o [*3] |-> !ccp_b_o)
    else $error("pin b driven outside pwm");
  a_oe_cause: assert property ($rose(ccp_b_oe_o) |-> $past(write_i) || $past(write_i, 2) || $past(write_i, 3))
    else $error("pin b enable rose without a write");
endmodule

// ===== test/general_timer_unit_test.sv
// self-checking bench of the general timer unit
`timescale 1ns/10ps
`include "gt_params.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t %h %h", $time, a, e); end end
module general_timer_unit_test;
  logic        clk_i = 0, rst_n_i = 0, read_i = 0, write_i = 0, waitrequest_o;
  logic [7:0]  address_i = 8'h00;
  logic [31:0] writedata_i = 32'h0, readdata_o, lfsr = 32'hD495, m, got_e, exp_q[$];
  logic        ccp_a_i, ccp_b_i, ccp_a_o, ccp_a_oe_o, ccp_b_o, ccp_b_oe_o;
  logic [1:0]  tog = 2'b00;
  logic        halt = 1'b0;
  int          err_total = 0, num_checks = 0, cyc = 0, hi, n;
  general_timer_unit #(.RTC_DIV(4)) general_timer_unit_i (
    .clk_i, .rst_n_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i(4'hF), .readdata_o,
    .waitrequest_o, .debug_halt_i(halt), .ccp_a_i, .ccp_b_i, .ccp_a_o, .ccp_a_oe_o, .ccp_b_o, .ccp_b_oe_o);
  gt_pins_model gt_pins_model_i (.clk_i, .tog_i(tog), .pin_a_o(ccp_a_i), .pin_b_o(ccp_b_i));
  always #2 clk_i = ~clk_i;
  // ----
  // tasks
  // ----
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // waitrequest is sampled at the rising edge; one idle edge after each transfer keeps requests apart
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address_i <= a;
    writedata_i <= d;
    read_i <= !wr;
    write_i <= wr;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0) @(posedge clk_i);
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pin(input int k);
    tog[k] <= 1'b1;
    @(posedge clk_i);
    tog[k] <= 1'b0;
    repeat (7) @(posedge clk_i);
  endtask
  task automatic meas(input int len, input int e);
    hi = 0;
    repeat (4) @(posedge clk_i);
    repeat (len) begin
      @(negedge clk_i);
      hi += (ccp_b_o === 1'b1);
    end
    @(posedge clk_i);
    `CHK(hi, e)
  endtask
  always @(posedge clk_i)
    if (read_i && waitrequest_o === 1'b0) begin
      got_e = exp_q.pop_front();
      `CHK(readdata_o, got_e)
    end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`GT_OFF_CFG, 32'h0);
    rd(`GT_OFF_LOAD_A, 32'hFFFFFFFF);
    rd(8'h50, 32'h0);
    lfsr = nxt(lfsr);
    n = lfsr[1:0] + 1;
    m = {24'h0, lfsr[15:8]};
    bus(1, `GT_OFF_CFG, 32'h4);
    bus(1, `GT_OFF_MODE_A, 32'h3);
    bus(1, `GT_OFF_LOAD_A, m + n);
    bus(1, `GT_OFF_MATCH_A, m);
    bus(1, `GT_OFF_IMR, 32'h2);
    bus(1, `GT_OFF_CTL, 32'h9);
    repeat (n + 2) pin(0);
    rd(`GT_OFF_COUNT_A, m + n);
    rd(`GT_OFF_CTL, 32'h8);
    rd(`GT_OFF_MIS, 32'h2);
    bus(1, `GT_OFF_ICR, 32'h2);
    rd(`GT_OFF_RIS, 32'h0);
    bus(1, `GT_OFF_CTL, 32'h0);
    if (ccp_a_i) pin(0);
    bus(1, `GT_OFF_MODE_A, 32'h7);
    bus(1, `GT_OFF_IMR, 32'h0);
    bus(1, `GT_OFF_LOAD_A, 32'hFFFF);
    bus(1, `GT_OFF_CTL, 32'h1);
    pin(0);
    rd(`GT_OFF_RIS, 32'h4);
    rd(`GT_OFF_COUNT_A, 32'hFFF9);
    rd(`GT_OFF_MIS, 32'h0);
    bus(1, `GT_OFF_ICR, 32'h4);
    pin(0);
    rd(`GT_OFF_RIS, 32'h0);
    rd(`GT_OFF_COUNT_A, 32'hFFF9);
    bus(1, `GT_OFF_CTL, 32'h0);
    bus(1, `GT_OFF_MODE_B, 32'hA);
    bus(1, `GT_OFF_LOAD_B, 32'h7);
    bus(1, `GT_OFF_MATCH_B, 32'h2);
    bus(1, `GT_OFF_CTL, 32'h100);
    `CHK(ccp_b_oe_o, 1'b1)
    meas(32, 20);
    bus(1, `GT_OFF_LOAD_B, 32'hF);
    meas(64, 52);
    bus(1, `GT_OFF_CTL, 32'h0);
    bus(1, `GT_OFF_LOAD_B, 32'hF);
    bus(1, `GT_OFF_CTL, 32'h4100);
    meas(64, 12);
    rd(`GT_OFF_RIS, 32'h0);
    bus(1, `GT_OFF_CTL, 32'h0);
    for (int md = 1; md < 3; md++) begin
      bus(1, `GT_OFF_MODE_A, md);
      bus(1, `GT_OFF_CTL, 32'h1);
      bus(1, `GT_OFF_LOAD_A, 32'h5);
      repeat (20) @(posedge clk_i);
      rd(`GT_OFF_CTL, md - 1);
      rd(`GT_OFF_RIS, 32'h1);
      bus(1, `GT_OFF_CTL, 32'h0);
      bus(1, `GT_OFF_ICR, 32'h1);
    end
    halt <= 1'b1;
    bus(1, `GT_OFF_CTL, 32'h3);
    repeat (20) @(posedge clk_i);
    rd(`GT_OFF_RIS, 32'h0);
    bus(1, `GT_OFF_CTL, 32'h13);
    repeat (20) @(posedge clk_i);
    rd(`GT_OFF_RIS, 32'h1);
    halt <= 1'b0;
    bus(1, `GT_OFF_CTL, 32'h0);
    bus(1, `GT_OFF_ICR, 32'h1);
    bus(1, `GT_OFF_CFG, 32'h1);
    bus(1, `GT_OFF_MATCH_A, 32'h2);
    bus(1, `GT_OFF_CTL, 32'h1);
    repeat (16) pin(0);
    repeat (4) @(posedge clk_i);
    rd(`GT_OFF_RIS, 32'h8);
    rd(`GT_OFF_COUNT_A, 32'h0);
    end_sim();
  end
endmodule
bind general_timer_unit general_timer_unit_asserts general_timer_unit_asserts_i (.clk_i, .rst_n_i, .read_i,
  .write_i, .readdata_o, .waitrequest_o, .ccp_a_o, .ccp_a_oe_o, .ccp_b_o, .ccp_b_oe_o);
